// [hw/idu_divide_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module idu_divide_unit (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Repeat setup with its divide target
  input wire logic i_repeat_load,
  input wire logic [13:0] i_repeat_value,
  input wire logic [2:0] i_div_op,
  input wire logic [3:0] i_dividend_sel,
  input wire logic [3:0] i_divisor_sel,
  // Interrupt pause between iterations
  input wire logic i_irq_hold,
  // Working register write and read ports
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [3:0] i_rd_addr,
  output logic [15:0] o_rd_data,
  // Status
  output logic o_busy,
  output logic o_done,
  output logic [13:0] o_repeat_count
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  idu_pkg::idu_state_t state_q, state_d;
  idu_pkg::idu_op_t op_q, op_d;
  logic [13:0] repeat_counter_q, repeat_counter_d;
  logic [4:0] iter_q, iter_d;
  logic [3:0] dvd_sel_q, dvd_sel_d;
  logic [3:0] dvs_sel_q, dvs_sel_d;
  logic [15:0] dvs_mag_q, dvs_mag_d;
  logic quot_neg_q, quot_neg_d;
  logic rem_neg_q, rem_neg_d;
  logic done_q, done_d;
  logic [15:0] rd_q, rd_d;
  logic [15:0] wreg_q [16];
  logic [15:0] wreg_d [16];

  // ----------------------------------------------------------------
  // Iteration datapath
  // ----------------------------------------------------------------
  logic step;
  logic is_signed;
  logic is_long;
  logic [15:0] src_lo;
  logic [15:0] src_hi;
  logic [15:0] src_dvs;
  logic [31:0] dvd_raw;
  logic [31:0] dvd_mag;
  logic dvd_neg;
  logic dvs_neg;
  logic [16:0] part;
  logic [16:0] diff;
  logic qbit;
  logic [15:0] res0_d;
  logic [15:0] res1_d;
  logic res_we;

  // A pending interrupt freezes the loop between two steps; the state
  // sits in the result registers and a few flops, so nothing is lost.
  assign step = (state_q == idu_pkg::IDU_RUN) && !i_irq_hold;

  always_comb begin
    is_signed = (op_q == idu_pkg::FRACTIONAL_DIVIDE_OP) ||
                (op_q == idu_pkg::SIGNED_LONG_DIVIDE_OP) ||
                (op_q == idu_pkg::SIGNED_WORD_DIVIDE_OP);
    is_long = (op_q == idu_pkg::SIGNED_LONG_DIVIDE_OP) ||
              (op_q == idu_pkg::UNSIGNED_LONG_DIVIDE_OP);
    src_lo = wreg_q[dvd_sel_q];
    src_hi = wreg_q[dvd_sel_q + 4'h1];
    src_dvs = wreg_q[dvs_sel_q];
    if (op_q == idu_pkg::FRACTIONAL_DIVIDE_OP) begin
      // Q15 by Q15: the dividend is scaled up by fifteen places
      dvd_raw = {src_lo[15], src_lo, 15'h0000};
    end else if (is_long) begin
      dvd_raw = {src_hi, src_lo};
    end else if (is_signed) begin
      dvd_raw = {{16{src_lo[15]}}, src_lo};
    end else begin
      dvd_raw = {16'h0000, src_lo};
    end
    dvd_neg = is_signed && dvd_raw[31];
    dvs_neg = is_signed && src_dvs[15];
    dvd_mag = dvd_neg ? 32'(~dvd_raw + 32'h0000_0001) : dvd_raw;
    // Restoring step on a 17-bit partial remainder
    part = {wreg_q[idu_pkg::SECOND_RESULT_IDX], wreg_q[idu_pkg::FIRST_RESULT_IDX][15]};
    diff = 17'(part - {1'b0, dvs_mag_q});
    qbit = !diff[16];
    res0_d = wreg_q[idu_pkg::FIRST_RESULT_IDX];
    res1_d = wreg_q[idu_pkg::SECOND_RESULT_IDX];
    res_we = 1'b0;
    if (step) begin
      res_we = 1'b1;
      if (iter_q == idu_pkg::ITER_SETUP) begin
        res1_d = dvd_mag[31:16];
        res0_d = dvd_mag[15:0];
      end else if (iter_q == idu_pkg::ITER_FIXUP) begin
        res0_d = quot_neg_q ? 16'(~res0_d + 16'h0001) : res0_d;
        res1_d = rem_neg_q ? 16'(~res1_d + 16'h0001) : res1_d;
      end else if (iter_q < idu_pkg::ITER_FIXUP) begin
        res0_d = {res0_d[14:0], qbit};
        res1_d = qbit ? diff[15:0] : part[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Repeat control
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    repeat_counter_d = repeat_counter_q;
    iter_d = iter_q;
    dvd_sel_d = dvd_sel_q;
    dvs_sel_d = dvs_sel_q;
    dvs_mag_d = dvs_mag_q;
    quot_neg_d = quot_neg_q;
    rem_neg_d = rem_neg_q;
    done_d = 1'b0;
    unique case (state_q)
      idu_pkg::IDU_IDLE: begin
        if (i_repeat_load) begin
          // The setup cycle counts as one of the eighteen
          repeat_counter_d = i_repeat_value;
          op_d = idu_pkg::idu_op_t'(i_div_op);
          dvd_sel_d = i_dividend_sel;
          dvs_sel_d = i_divisor_sel;
          iter_d = idu_pkg::ITER_SETUP;
          state_d = idu_pkg::IDU_RUN;
        end
      end
      idu_pkg::IDU_RUN: begin
        if (step) begin
          if (iter_q == idu_pkg::ITER_SETUP) begin
            dvs_mag_d = dvs_neg ? 16'(~src_dvs + 16'h0001) : src_dvs;
            quot_neg_d = dvd_neg ^ dvs_neg;
            rem_neg_d = dvd_neg;
          end
          // A wrong repeat value runs short or long; no guard, by design
          if (iter_q != 5'h1f) begin
            iter_d = 5'(iter_q + 5'h01);
          end
          if (repeat_counter_q == idu_pkg::REPEAT_COUNTER_RESET) begin
            state_d = idu_pkg::IDU_IDLE;
            done_d = 1'b1;
          end else begin
            repeat_counter_d = 14'(repeat_counter_q - 14'h0001);
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wreg
      always_comb begin
        wreg_d[gi] = wreg_q[gi];
        if (res_we && (4'(gi) == idu_pkg::FIRST_RESULT_IDX)) begin
          wreg_d[gi] = res0_d;
        end else if (res_we && (4'(gi) == idu_pkg::SECOND_RESULT_IDX)) begin
          wreg_d[gi] = res1_d;
        end else if (i_wr_en && (i_wr_addr == 4'(gi))) begin
          wreg_d[gi] = i_wr_data;
        end
      end
      always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          wreg_q[gi] <= idu_pkg::REG_RESET;
        end else if (i_clk_en) begin
          wreg_q[gi] <= wreg_d[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_d = wreg_q[i_rd_addr];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= idu_pkg::IDU_IDLE;
      op_q <= idu_pkg::FRACTIONAL_DIVIDE_OP;
      repeat_counter_q <= idu_pkg::REPEAT_COUNTER_RESET;
      iter_q <= idu_pkg::ITER_SETUP;
      dvd_sel_q <= 4'h0;
      dvs_sel_q <= 4'h0;
      dvs_mag_q <= idu_pkg::REG_RESET;
      quot_neg_q <= 1'b0;
      rem_neg_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= idu_pkg::REG_RESET;
    end else if (i_clk_en) begin
      state_q <= state_d;
      op_q <= op_d;
      repeat_counter_q <= repeat_counter_d;
      iter_q <= iter_d;
      dvd_sel_q <= dvd_sel_d;
      dvs_sel_q <= dvs_sel_d;
      dvs_mag_q <= dvs_mag_d;
      quot_neg_q <= quot_neg_d;
      rem_neg_q <= rem_neg_d;
      done_q <= done_d;
      rd_q <= rd_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_busy = state_q;
  assign o_done = done_q;
  assign o_repeat_count = repeat_counter_q;

endmodule
`default_nettype wire

// [hw/idu_pkg.sv]
package idu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned REPEAT_COUNTER_W = 14;
  localparam int unsigned ITER_W = 5;

  // ----------------------------------------------------------------
  // Fixed result registers
  // ----------------------------------------------------------------
  localparam logic [REG_IDX_W-1:0] FIRST_RESULT_IDX = 4'h0;
  localparam logic [REG_IDX_W-1:0] SECOND_RESULT_IDX = 4'h1;

  // ----------------------------------------------------------------
  // Iteration plan: setup, sixteen quotient steps, sign fixup
  // ----------------------------------------------------------------
  localparam logic [ITER_W-1:0] DIV_ITERATIONS = 5'h12;
  localparam logic [ITER_W-1:0] ITER_SETUP = 5'h00;
  localparam logic [ITER_W-1:0] ITER_FIXUP = 5'h11;
  localparam logic [REPEAT_COUNTER_W-1:0] REPEAT_COUNTER_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Divide operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FRACTIONAL_DIVIDE_OP = 3'b000,
    SIGNED_LONG_DIVIDE_OP = 3'b001,
    UNSIGNED_LONG_DIVIDE_OP = 3'b010,
    SIGNED_WORD_DIVIDE_OP = 3'b011,
    UNSIGNED_WORD_DIVIDE_OP = 3'b100
  } idu_op_t;

  typedef enum logic [0:0] {
    IDU_IDLE = 1'b0,
    IDU_RUN = 1'b1
  } idu_state_t;

endpackage

// [verification/idu_divide_checker_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module idu_divide_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Repeat setup and pause
  input wire logic i_repeat_load,
  input wire logic [13:0] i_repeat_value,
  input wire logic [2:0] i_div_op,
  input wire logic [3:0] i_dividend_sel,
  input wire logic [3:0] i_divisor_sel,
  input wire logic i_irq_hold,
  // Register ports
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [3:0] i_rd_addr,
  input wire logic [15:0] o_rd_data,
  // Status
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [13:0] o_repeat_count
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire go = i_repeat_load && !o_busy && i_clk_en;
  wire step = o_busy && i_clk_en && !i_irq_hold;
  chk_load_count:
    assert property (go |=> o_busy && o_repeat_count == $past(i_repeat_value))
      else $error("no load");
  chk_count_step:
    assert property (step && o_repeat_count != 14'h0 |=> o_busy &&
      o_repeat_count == $past(o_repeat_count) - 14'h1) else $error("bad step");
  chk_last_done:
    assert property (step && o_repeat_count == 14'h0 |=> o_done && !o_busy)
      else $error("late end");
  chk_hold_freeze:
    assert property (o_busy && !step |=> o_busy && $stable(o_repeat_count) && !o_done)
      else $error("pause lost");
  chk_done_single:
    assert property (o_done && i_clk_en |=> !o_done) else $error("long done");
  chk_done_busy:
    assert property ($rose(o_done) |-> $past(o_busy)) else $error("stray done");
  chk_idle_still:
    assert property (!o_busy && !i_repeat_load |=> !o_busy && $stable(o_repeat_count))
      else $error("self start");
  chk_busy_ends:
    assert property ($fell(o_busy) |-> o_done) else $error("end without done");
endmodule
bind idu_divide_unit idu_divide_checker u_chk (.*);
`default_nettype wire

// [verification/idu_sequencer_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Issues each divide only through a repeat setup; never a bare divide
module idu_sequencer_model (
  input wire logic i_clock,
  input wire logic i_issue,
  output logic o_repeat_load,
  output logic [13:0] o_repeat_value
);
  always @(negedge i_clock) begin
    o_repeat_load <= i_issue;
  end
  // Operand 17 so the divide step runs eighteen times
  assign o_repeat_value = 14'h0011;
endmodule
`default_nettype wire

// [verification/iterative_divide_unit_test.sv]
`timescale 1ns/100ps
`default_nettype none
module iterative_divide_unit_test;
  logic i_clock = 0, i_rst_b = 0, i_clk_en = 1, issue = 0, i_irq_hold = 0, i_wr_en = 0;
  logic [2:0] i_div_op = 3'h0;
  logic [3:0] i_dividend_sel = 4'h0, i_divisor_sel = 4'h0, i_wr_addr = 4'h0, i_rd_addr = 4'h0;
  logic [15:0] i_wr_data = 16'h0, o_rd_data;
  logic [13:0] rep_val, o_repeat_count;
  logic rep_load, o_busy, o_done;
  int bad_count = 0, n_compared = 0, n = 0;
  always #12.5 i_clock = ~i_clock;
  idu_sequencer_model seq (.i_clock(i_clock), .i_issue(issue), .o_repeat_load(rep_load),
    .o_repeat_value(rep_val));
  idu_divide_unit dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_repeat_load(rep_load), .i_repeat_value(rep_val), .i_div_op(i_div_op),
    .i_dividend_sel(i_dividend_sel), .i_divisor_sel(i_divisor_sel), .i_irq_hold(i_irq_hold),
    .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_busy(o_busy), .o_done(o_done), .o_repeat_count(o_repeat_count));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge i_clock); i_wr_en = 1; i_wr_addr = a; i_wr_data = d;
    @(negedge i_clock); i_wr_en = 0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(negedge i_clock); i_rd_addr = a;
    @(negedge i_clock); v = o_rd_data;
  endtask
  task start(input logic [2:0] op, input logic [3:0] s, input logic [3:0] v);
    @(negedge i_clock); i_div_op = op; i_dividend_sel = s; i_divisor_sel = v; issue <= 1;
    @(negedge i_clock); issue <= 0; n = 0;
  endtask
  // Bounded so a lost done shows as a wrong count, not a hang
  task wait_done;
    do begin @(negedge i_clock); n++; end while (o_done !== 1'b1 && n < 60);
  endtask
  task div_case(input logic [2:0] op, input logic [3:0] s, input logic [3:0] v,
    input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] dv,
    input logic [15:0] q, input logic [15:0] r);
    logic [15:0] got;
    wr(s, lo); wr(s + 4'h1, hi); wr(v, dv);
    start(op, s, v); wait_done;
    check(16'(n), 16'h13);
    rd(4'h0, got); check(got, q);
    rd(4'h1, got); check(got, r);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_ops;
    div_case(3'h0, 4'h6, 4'h9, 16'he000, 16'ha5a5, 16'h4000, 16'hc000, 16'h0000);
    div_case(3'h1, 4'h4, 4'h3, 16'hdcbb, 16'hfffe, 16'h0100, 16'hfedd, 16'hffbb);
    div_case(3'h2, 4'h4, 4'h3, 16'h2345, 16'h0001, 16'h0100, 16'h0123, 16'h0045);
    div_case(3'h3, 4'hc, 4'hf, 16'hff9c, 16'ha5a5, 16'h0007, 16'hfff2, 16'hfffe);
    div_case(3'h4, 4'hc, 4'hf, 16'hff9c, 16'ha5a5, 16'h0007, 16'h2484, 16'h0000);
  endtask
  // Load held high: refused while busy, taken again in the done cycle
  task t_back;
    logic [15:0] got;
    @(negedge i_clock); i_div_op = 3'h2; i_dividend_sel = 4'h4; i_divisor_sel = 4'h3;
    issue <= 1;
    @(negedge i_clock); n = 0; wait_done; check(16'(n), 16'h13);
    issue <= 0; n = 0; wait_done; check(16'(n), 16'h13);
    rd(4'h0, got); check(got, 16'h0123);
  endtask
  // Pause mid-divide, service code touches an unrelated register
  task t_irq;
    logic [15:0] got;
    start(3'h3, 4'hc, 4'hf);
    repeat (3) @(negedge i_clock);
    i_irq_hold = 1;
    wr(4'h7, 16'h1234);
    check(16'(o_repeat_count), 16'h000f);
    check({15'h0000, o_busy}, 16'h0001);
    i_irq_hold = 0;
    i_clk_en = 0;
    @(negedge i_clock); i_clk_en = 1; n = 6; wait_done;
    check(16'(n), 16'h16);
    rd(4'h0, got); check(got, 16'hfff2);
    rd(4'h1, got); check(got, 16'hfffe);
    rd(4'h7, got); check(got, 16'h1234);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    logic [15:0] got;
    repeat (10) @(negedge i_clock);
    i_rst_b = 1;
    rd(4'h0, got); check(got, 16'h0000);
    t_ops; t_back; t_irq;
    final_report;
  end
  initial begin
    #75000;
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
